// File: hdl/txcfs_pkg.sv
// Package with register map, field positions and types of the tx clock and frame sync block
package txcfs_pkg;
   // Register byte addresses
   localparam logic [3:0] TXCFS_FSCTL_ADDR  = 4'h0;
   localparam logic [3:0] TXCFS_CKCTL_ADDR  = 4'h4;
   localparam logic [3:0] TXCFS_HCCTL_ADDR  = 4'h8;
   localparam logic [3:0] TXCFS_STAT_ADDR   = 4'hC;
   // Frame sync control fields
   localparam int TXCFS_MODE_LSB  = 7;
   localparam int TXCFS_MODE_MSB  = 15;
   localparam int TXCFS_WID_BIT   = 4;
   localparam int TXCFS_SRC_BIT   = 1;
   localparam int TXCFS_POL_BIT   = 0;
   // Bit clock control fields
   localparam int TXCFS_EDGE_BIT  = 7;
   localparam int TXCFS_INDEP_BIT = 6;
   localparam int TXCFS_CSRC_BIT  = 5;
   localparam int TXCFS_DIV_MSB   = 4;
   // High clock control fields
   localparam int TXCFS_HSRC_BIT  = 15;
   localparam int TXCFS_HDIV_MSB  = 11;
   // Writable masks; other bits are reserved
   localparam logic [31:0] TXCFS_FSCTL_MASK = 32'h0000_FF93;
   localparam logic [31:0] TXCFS_CKCTL_MASK = 32'h0000_00FF;
   localparam logic [31:0] TXCFS_HCCTL_MASK = 32'h0000_8FFF;
   // Reset values
   localparam logic [31:0] TXCFS_FSCTL_RST  = 32'h0000_0000;
   localparam logic [31:0] TXCFS_CKCTL_RST  = 32'h0000_0000;
   localparam logic [31:0] TXCFS_HCCTL_RST  = 32'h0000_0000;
   // Mode codes
   localparam logic [8:0] TXCFS_MODE_BURST = 9'h000;
   localparam logic [8:0] TXCFS_MODE_TDMLO = 9'h002;
   localparam logic [8:0] TXCFS_MODE_TDMHI = 9'h020;
   localparam logic [8:0] TXCFS_MODE_DAUD  = 9'h180;
   localparam logic [8:0] TXCFS_DAUD_SLOTS = 9'h180;
   // Bits per slot (word) used for frame timing
   localparam logic [5:0] TXCFS_SLOT_BITS  = 6'h20;
   typedef struct packed {
      logic [31:0] address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
   } txcfs_req_t;
   typedef struct packed {
      logic [31:0] readdata;
      logic        waitrequest;
      logic        readdatavalid;
   } txcfs_rsp_t;
   typedef enum logic [1:0] {TXCFS_IDLE, TXCFS_ACK} txcfs_bus_t;
endpackage

// File: hdl/txcfs_top.sv
// Transmit bit clock, high clock and frame sync generator with Avalon-MM registers
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Frame mode in bits 15:7; zero means burst, a frame of one slot.
// - Modes 2h-20h are TDM slots, 180h is 384-slot mode, others reserved.
// - Bit 4 sets sync width: one bit clock or one whole word.
// - Bit 1: zero accepts external frame sync, one generates and drives it.
// - Bit 0: zero rising edge starts frame, one falling edge.
// - Reserved bits read zero and writes to them change nothing.
// - Bit 7: zero launches data on rising clock edge, one on falling.
// - Bit 6: zero shares tx clocks with receive, one keeps them separate.
// - Bit 5: zero takes bit clock from pin, one from divider and drives it.
// - Bits 4:0 divide high clock by value plus one to make bit clock.
// - High clock from pin or twelve-bit divider of auxiliary clock.
// - Internal bit clock at divide-by-one passes high clock straight through.
module txcfs_top
   import txcfs_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // Avalon-MM slave
   input  wire txcfs_pkg::txcfs_req_t avs_req,
   output var  txcfs_pkg::txcfs_rsp_t avs_rsp,
   // Clock pins
   input  wire logic        aux_in,
   input  wire logic        hclk_pin_in,
   input  wire logic        bclk_pin_in,
   output logic             bclk_out,
   output logic             bclk_oe,
   // Frame sync pin
   input  wire logic        fs_pin_in,
   output logic             fs_out,
   output logic             fs_oe,
   // Derived controls for data and receive logic
   output logic             launch_strobe,
   output logic             frame_start,
   output logic             rx_share_clk
);
   import txcfs_pkg::*;

   function automatic logic sync3(input logic [2:0] s, input logic prev);
      sync3 = (s[2] == s[1]) ? s[1] : prev;
   endfunction

   logic [31:0] fs_reg, fs_next, ck_reg, ck_next, hc_reg, hc_next;
   txcfs_bus_t  st_reg, st_next;
   txcfs_rsp_t  rsp_reg, rsp_next;
   logic [2:0]  aux_s_reg, hp_s_reg, bp_s_reg, fp_s_reg;
   logic        aux_f_reg, hp_f_reg, bp_f_reg, fp_f_reg;
   logic [11:0] hcnt_reg, hcnt_next;
   logic        hint_reg, hint_next;
   logic        hclk_prev_reg;
   logic [4:0]  bcnt_reg, bcnt_next;
   logic        bint_reg, bint_next;
   logic        bclk_prev_reg;
   logic [5:0]  bit_reg, bit_next;
   logic [8:0]  slot_reg, slot_next;
   logic        fsgen_reg, fsgen_next;
   logic        fsin_prev_reg;
   logic        bco_reg, bco_next, bcoe_reg, bcoe_next;
   logic        fso_reg, fso_next, fsoe_reg, fsoe_next;
   logic        ls_reg, ls_next, fst_reg, fst_next, shr_reg;

   logic [8:0]  mode;
   logic        wid, fsrc, fpol, edge_sel, csrc, hsrc;
   logic [4:0]  bdiv;
   logic [11:0] hdiv;
   logic        hclk, hrise, bclk, brise, bfall, launch, ext_start;
   logic [8:0]  nslots;
   logic        mode_ok;
   logic        addr_hit;

   // Full decode so that addresses above the map alias nothing
   assign addr_hit = (avs_req.address[31:4] == 28'h0000000);

   assign mode     = fs_reg[TXCFS_MODE_MSB:TXCFS_MODE_LSB];
   assign wid      = fs_reg[TXCFS_WID_BIT];
   assign fsrc     = fs_reg[TXCFS_SRC_BIT];
   assign fpol     = fs_reg[TXCFS_POL_BIT];
   assign edge_sel = ck_reg[TXCFS_EDGE_BIT];
   assign csrc     = ck_reg[TXCFS_CSRC_BIT];
   assign bdiv     = ck_reg[TXCFS_DIV_MSB:0];
   assign hsrc     = hc_reg[TXCFS_HSRC_BIT];
   assign hdiv     = hc_reg[TXCFS_HDIV_MSB:0];

   // Register bus: one wait cycle, then acknowledge
   always_comb begin
      st_next  = st_reg;
      fs_next  = fs_reg;
      ck_next  = ck_reg;
      hc_next  = hc_reg;
      rsp_next = '{readdata: 32'h0000_0000, waitrequest: 1'b1, readdatavalid: 1'b0};
      case (st_reg)
         TXCFS_IDLE: begin
            if (avs_req.read || avs_req.write) begin
               st_next = TXCFS_ACK;
               rsp_next.waitrequest = 1'b0;
               if (avs_req.read) begin
                  rsp_next.readdatavalid = 1'b1;
                  if (addr_hit) begin
                     case (avs_req.address[3:0])
                        TXCFS_FSCTL_ADDR: rsp_next.readdata = fs_reg;
                        TXCFS_CKCTL_ADDR: rsp_next.readdata = ck_reg;
                        TXCFS_HCCTL_ADDR: rsp_next.readdata = hc_reg;
                        TXCFS_STAT_ADDR:  rsp_next.readdata = {23'h0, slot_reg};
                        default:          rsp_next.readdata = 32'h0000_0000;
                     endcase
                  end
               end
            end
         end
         // Write lands on the edge where the master sees waitrequest low
         TXCFS_ACK: begin
            st_next = TXCFS_IDLE;
            if (avs_req.write && addr_hit) begin
               case (avs_req.address[3:0])
                  TXCFS_FSCTL_ADDR: fs_next = avs_req.writedata & TXCFS_FSCTL_MASK;
                  TXCFS_CKCTL_ADDR: ck_next = avs_req.writedata & TXCFS_CKCTL_MASK;
                  TXCFS_HCCTL_ADDR: hc_next = avs_req.writedata & TXCFS_HCCTL_MASK;
                  default: ;
               endcase
            end
         end
         default:   st_next = TXCFS_IDLE;
      endcase
   end

   // Pin qualification on three stages
   assign hclk = hsrc ? hint_reg : hp_f_reg;
   assign hrise = hclk & ~hclk_prev_reg;
   // High clock divider from auxiliary clock, value plus one
   always_comb begin
      hcnt_next = hcnt_reg;
      hint_next = hint_reg;
      if (hdiv == 12'h000) begin
         hint_next = aux_f_reg;
         hcnt_next = 12'h000;
      end else if (sync3(aux_s_reg, aux_f_reg) && !aux_f_reg) begin
         if (hcnt_reg >= hdiv) begin
            hcnt_next = 12'h000;
            hint_next = 1'b1;
         end else begin
            hcnt_next = hcnt_reg + 12'h001;
            if (hcnt_reg == {1'b0, hdiv[11:1]}) hint_next = 1'b0;
         end
      end
   end

   // Bit clock divider: one bit clock period every value plus one high clock rising edges
   always_comb begin
      bcnt_next = bcnt_reg;
      bint_next = bint_reg;
      if (bdiv == 5'h00) begin
         bint_next = hclk;
         bcnt_next = 5'h00;
      end else if (hrise) begin
         if (bcnt_reg >= bdiv) begin
            bcnt_next = 5'h00;
            bint_next = 1'b1;
         end else begin
            bcnt_next = bcnt_reg + 5'h01;
            if (bcnt_reg == {1'b0, bdiv[4:1]}) bint_next = 1'b0;
         end
      end
   end

   assign bclk  = csrc ? bint_reg : bp_f_reg;
   assign brise = bclk & ~bclk_prev_reg;
   assign bfall = ~bclk & bclk_prev_reg;
   assign launch = edge_sel ? bfall : brise;
   assign mode_ok = (mode >= TXCFS_MODE_TDMLO && mode <= TXCFS_MODE_TDMHI) ||
                    (mode == TXCFS_MODE_DAUD);
   assign nslots = (mode == TXCFS_MODE_DAUD) ? TXCFS_DAUD_SLOTS : mode;
   assign ext_start = fpol ? (~fp_f_reg & fsin_prev_reg) : (fp_f_reg & ~fsin_prev_reg);

   // Frame counter: bits per slot, slots per frame
   always_comb begin
      bit_next   = bit_reg;
      slot_next  = slot_reg;
      fsgen_next = fsgen_reg;
      fst_next   = 1'b0;
      if (!fsrc && ext_start) begin
         bit_next  = 6'h00;
         slot_next = 9'h000;
         fst_next  = 1'b1;
      end else if (launch) begin
         if (bit_reg == TXCFS_SLOT_BITS - 6'h01) begin
            bit_next = 6'h00;
            if (mode == TXCFS_MODE_BURST || !mode_ok || slot_reg >= nslots - 9'h001) begin
               slot_next = 9'h000;
            end else begin
               slot_next = slot_reg + 9'h001;
            end
         end else begin
            bit_next = bit_reg + 6'h01;
         end
         if (fsrc) begin
            fsgen_next = (mode_ok || mode == TXCFS_MODE_BURST) && slot_next == 9'h000 &&
                         (wid || bit_next == 6'h00);
            fst_next = fsgen_next && bit_next == 6'h00;
         end
      end
      if (!fsrc) fsgen_next = 1'b0;
   end

   always_comb begin
      bco_next  = bclk;
      bcoe_next = csrc;
      fso_next  = fsgen_reg ^ fpol;
      fsoe_next = fsrc;
      ls_next   = launch;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg <= TXCFS_IDLE;
         rsp_reg <= '{readdata: 32'h0000_0000, waitrequest: 1'b1, readdatavalid: 1'b0};
         fs_reg <= TXCFS_FSCTL_RST;
         ck_reg <= TXCFS_CKCTL_RST;
         hc_reg <= TXCFS_HCCTL_RST;
         aux_s_reg <= 3'h0;
         hp_s_reg <= 3'h0;
         bp_s_reg <= 3'h0;
         fp_s_reg <= 3'h0;
         aux_f_reg <= 1'b0;
         hp_f_reg <= 1'b0;
         bp_f_reg <= 1'b0;
         fp_f_reg <= 1'b0;
         hcnt_reg <= 12'h000;
         hint_reg <= 1'b0;
         hclk_prev_reg <= 1'b0;
         bcnt_reg <= 5'h00;
         bint_reg <= 1'b0;
         bclk_prev_reg <= 1'b0;
         bit_reg <= 6'h00;
         slot_reg <= 9'h000;
         fsgen_reg <= 1'b0;
         fsin_prev_reg <= 1'b0;
         bco_reg <= 1'b0;
         bcoe_reg <= 1'b0;
         fso_reg <= 1'b0;
         fsoe_reg <= 1'b0;
         ls_reg <= 1'b0;
         fst_reg <= 1'b0;
         shr_reg <= 1'b1;
      end else begin
         st_reg <= st_next;
         rsp_reg <= rsp_next;
         fs_reg <= fs_next;
         ck_reg <= ck_next;
         hc_reg <= hc_next;
         // Stage 0 is only read by stage 1
         aux_s_reg <= {aux_s_reg[1:0], aux_in};
         hp_s_reg <= {hp_s_reg[1:0], hclk_pin_in};
         bp_s_reg <= {bp_s_reg[1:0], bclk_pin_in};
         fp_s_reg <= {fp_s_reg[1:0], fs_pin_in};
         aux_f_reg <= sync3(aux_s_reg, aux_f_reg);
         hp_f_reg <= sync3(hp_s_reg, hp_f_reg);
         bp_f_reg <= sync3(bp_s_reg, bp_f_reg);
         fp_f_reg <= sync3(fp_s_reg, fp_f_reg);
         hcnt_reg <= hcnt_next;
         hint_reg <= hint_next;
         hclk_prev_reg <= hclk;
         bcnt_reg <= bcnt_next;
         bint_reg <= bint_next;
         bclk_prev_reg <= bclk;
         bit_reg <= bit_next;
         slot_reg <= slot_next;
         fsgen_reg <= fsgen_next;
         fsin_prev_reg <= fp_f_reg;
         bco_reg <= bco_next;
         bcoe_reg <= bcoe_next;
         fso_reg <= fso_next;
         fsoe_reg <= fsoe_next;
         ls_reg <= ls_next;
         fst_reg <= fst_next;
         shr_reg <= ~ck_reg[TXCFS_INDEP_BIT];
      end
   end

   assign avs_rsp = rsp_reg;
   assign bclk_out = bco_reg;
   assign bclk_oe = bcoe_reg;
   assign fs_out = fso_reg;
   assign fs_oe = fsoe_reg;
   assign launch_strobe = ls_reg;
   assign frame_start = fst_reg;
   assign rx_share_clk = shr_reg;

   a_bclk_drive: assert property (@(posedge clk) disable iff (!rst_b)
      bcoe_reg == $past(csrc)) else $error("bit clock enable wrong");
   a_fs_drive: assert property (@(posedge clk) disable iff (!rst_b)
      fsoe_reg == $past(fsrc)) else $error("frame sync enable wrong");
   a_fs_pol: assert property (@(posedge clk) disable iff (!rst_b)
      fso_reg == ($past(fsgen_reg) ^ $past(fpol))) else $error("sync polarity wrong");
   a_resv_zero: assert property (@(posedge clk) disable iff (!rst_b)
      (fs_reg & ~TXCFS_FSCTL_MASK) == 32'h0 && (ck_reg & ~TXCFS_CKCTL_MASK) == 32'h0)
      else $error("reserved bit set");
   a_share_clk: assert property (@(posedge clk) disable iff (!rst_b)
      rx_share_clk == !$past(ck_reg[TXCFS_INDEP_BIT])) else $error("share flag wrong");
   a_div_pass: assert property (@(posedge clk) disable iff (!rst_b)
      bdiv == 5'h00 && $past(bdiv) == 5'h00 |-> bint_reg == $past(hclk))
      else $error("divide by one not passed");
   a_bit_range: assert property (@(posedge clk) disable iff (!rst_b)
      bit_reg < TXCFS_SLOT_BITS) else $error("bit counter overflow");
   // A mode change may leave the count high until its slot ends, so only the step is checked
   a_slot_range: assert property (@(posedge clk) disable iff (!rst_b)
      mode_ok && slot_reg < nslots ##1 $stable(mode) |-> slot_reg < nslots)
      else $error("slot counter overflow");
   a_burst_slot: assert property (@(posedge clk) disable iff (!rst_b)
      mode == TXCFS_MODE_BURST && $past(mode) == TXCFS_MODE_BURST && $past(launch) &&
      $past(bit_reg) == 6'h1F |-> slot_reg == 9'h000) else $error("burst slot advanced");
   a_wid_bit: assert property (@(posedge clk) disable iff (!rst_b)
      $past(launch && fsrc && !wid) |-> !fsgen_reg || bit_reg == 6'h00)
      else $error("single bit sync too wide");
   a_hdiv_cnt: assert property (@(posedge clk) disable iff (!rst_b)
      hcnt_reg <= hdiv || $changed(hdiv) || $past(hcnt_reg) > $past(hdiv))
      else $error("high divider overrun");
   a_launch_edge: assert property (@(posedge clk) disable iff (!rst_b)
      launch_strobe == ($past(edge_sel) ? $past(bfall) : $past(brise)))
      else $error("launch edge wrong");
   c_frame_int: cover property (@(posedge clk) disable iff (!rst_b) fsrc && fst_reg);
   c_frame_ext: cover property (@(posedge clk) disable iff (!rst_b) !fsrc && fst_reg);
   c_daud_mode: cover property (@(posedge clk) disable iff (!rst_b)
      mode == TXCFS_MODE_DAUD && slot_reg == 9'h17F);
   c_read_ack: cover property (@(posedge clk) disable iff (!rst_b) rsp_reg.readdatavalid);
endmodule
`default_nettype wire

// File: sim/tx_clock_frame_sync_control_tb.sv
// Self-checking bench for the tx clock and frame sync block
`timescale 1ns/1ps
`default_nettype none
module tx_clock_frame_sync_control_tb;
   import txcfs_pkg::*;
   logic              clk;
   logic              rst_b;
   txcfs_req_t        avs_req;
   txcfs_rsp_t        avs_rsp;
   logic              aux_clk, hclk, bclk_pin, fs_pin;
   logic              bclk_out, bclk_oe, fs_out, fs_oe;
   logic              launch_strobe, frame_start, rx_share_clk;
   int                err_count, n_checks, g, hi, st, i, w, seed;
   logic [31:0]       d, q;
   logic [8:0]        md [5] = '{9'h000, 9'h002, 9'h020, 9'h002, 9'h000};
   logic [4:0]        wd = 5'b01010;
   logic [4:0]        pl = 5'b01100;
   logic [31:0]       ck [5] = '{32'h20, 32'h23, 32'hA0, 32'h60, 32'h00};
   logic [31:0]       hc [5] = '{32'h0, 32'h0, 32'h0, 32'h8001, 32'h0};
   int                bp [5] = '{8, 32, 8, 16, 12};

   txcfs_top u_dut (.clk(clk), .rst_b(rst_b), .avs_req(avs_req), .avs_rsp(avs_rsp),
      .aux_in(aux_clk), .hclk_pin_in(hclk), .bclk_pin_in(bclk_pin),
      .bclk_out(bclk_out), .bclk_oe(bclk_oe), .fs_pin_in(fs_pin), .fs_out(fs_out),
      .fs_oe(fs_oe), .launch_strobe(launch_strobe), .frame_start(frame_start),
      .rx_share_clk(rx_share_clk));
   txcfs_codec_model u_codec (.aux_clk(aux_clk), .hclk(hclk), .bclk(bclk_pin), .fs(fs_pin));

   initial clk = 1'b0;
   always #12.5 clk = ~clk;

   function automatic logic [31:0] fsw(input logic [8:0] m, input logic wi, s, p);
      return {16'h0000, m, 2'b00, wi, 2'b00, s, p};
   endfunction
   function automatic int frame_len(input logic [8:0] m, input int b);
      return ((m == 9'h000) ? 1 : int'(m)) * 32 * b;
   endfunction

   task automatic end_sim;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] gv);
      n_checks++;
      if (gv !== e) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, gv);
      end
   endtask
   task automatic chk_near(input string nm, input int e, input int gv, input int tol);
      n_checks++;
      if (gv < e - tol || gv > e + tol) begin
         err_count++;
         $display("[ERR] %s expected %0d seen %0d", nm, e, gv);
      end
   endtask
   // Holds the request until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] dv,
                      output logic [31:0] rv);
      avs_req <= '{address: {24'h0, a}, read: ~wr, write: wr, writedata: dv};
      // No timeout here; only the watchdog ends a wait that never sees waitrequest low
      do begin
         @(posedge clk);
      end while (avs_rsp.waitrequest !== 1'b0);
      rv = avs_rsp.readdata;
      chk("readdatavalid", {31'h0, ~wr}, {31'h0, avs_rsp.readdatavalid});
      avs_req <= '0;
      @(posedge clk);
   endtask
   task automatic cfg(input logic [31:0] f, c, h);
      logic [31:0] r;
      bus(1'b1, 8'h08, h, r);
      bus(1'b1, 8'h04, c, r);
      bus(1'b1, 8'h00, f, r);
   endtask
   // Interval between two frame starts, with fs_out-high and strobe counts
   task automatic meas(input int lim, output int gv, output int h, output int s);
      int n;
      n = 0;
      gv = 0;
      h = 0;
      s = 0;
      while (frame_start !== 1'b1 && n < lim) begin
         @(posedge clk);
         n++;
      end
      if (n >= lim) begin
         gv = -1;
         return;
      end
      do begin
         @(posedge clk);
         gv++;
         h += (fs_out === 1'b1);
         s += (launch_strobe === 1'b1);
      end while (frame_start !== 1'b1 && gv < lim);
   endtask

   initial begin
      #1_500_000;
      err_count++;
      end_sim();
   end

   initial begin
      seed = 32'h55ce;
      err_count = 0;
      n_checks = 0;
      rst_b = 1'b0;
      avs_req = '0;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      for (i = 0; i < 3; i++) begin
         bus(1'b0, 8'(i * 4), 32'h0, q);
         chk("reset value", 32'h0, q);
      end
      chk("rx share after reset", 32'h1, {31'h0, rx_share_clk});
      // Random words, reserved bits included, must come back masked
      for (i = 0; i < 8; i++) begin
         d = $random(seed);
         bus(1'b1, 8'((i % 2) * 4), d, q);
         bus(1'b0, 8'((i % 2) * 4), 32'h0, q);
         chk("readback", d & ((i % 2) ? TXCFS_CKCTL_MASK : TXCFS_FSCTL_MASK), q);
         if (i % 2) begin
            chk("bclk_oe", {31'h0, d[5]}, {31'h0, bclk_oe});
            chk("rx share", {31'h0, ~d[6]}, {31'h0, rx_share_clk});
         end else
            chk("fs_oe", {31'h0, d[1]}, {31'h0, fs_oe});
      end
      bus(1'b1, 8'h10, 32'hFFFF_FFFF, q);
      bus(1'b0, 8'h10, 32'h0, q);
      chk("unmapped", 32'h0, q);
      bus(1'b1, 8'h00, fsw(9'h180, 1'b0, 1'b0, 1'b0), q);
      bus(1'b0, 8'h00, 32'h0, q);
      chk("mode 180h", fsw(9'h180, 1'b0, 1'b0, 1'b0), q);
      // Reserved bits written as zero from here on
      for (i = 0; i < 5; i++) begin
         cfg(fsw(md[i], wd[i], 1'b1, pl[i]), ck[i], hc[i]);
         meas(20000, g, hi, st);
         meas(20000, g, hi, st);
         w = wd[i] ? 32 * bp[i] : bp[i];
         chk_near("frame gap", frame_len(md[i], bp[i]), g, 4);
         chk_near("sync active", pl[i] ? g - w : w, hi, 4);
         chk_near("strobes", g / bp[i], st, 1);
         while (launch_strobe !== 1'b1) @(posedge clk);
         chk("launch edge", {31'h0, ~ck[i][7]}, {31'h0, bclk_out});
         chk("bclk_oe", {31'h0, ck[i][5]}, {31'h0, bclk_oe});
         chk("fs_oe", 32'h1, {31'h0, fs_oe});
      end
      cfg(fsw(9'h000, 1'b0, 1'b0, 1'b0), 32'h20, 32'h0);
      meas(3000, g, hi, st);
      meas(3000, g, hi, st);
      chk_near("external sync gap", 80, g, 4);
      chk("fs_oe external", 32'h0, {31'h0, fs_oe});
      cfg(fsw(9'h021, 1'b0, 1'b1, 1'b0), 32'h20, 32'h0);
      repeat (600) @(posedge clk);
      meas(3000, g, hi, st);
      chk_near("reserved mode", -1, g, 0);
      end_sim();
   end
endmodule
`default_nettype wire

// File: sim/txcfs_codec_model.sv
// Far-side codec model: free-running source clocks and an external frame sync
`timescale 1ns/1ps
`default_nettype none
module txcfs_codec_model (
   // Clocks offered to the device
   output logic aux_clk,
   output logic hclk,
   output logic bclk,
   // Frame sync offered to the device
   output logic fs
);
   // Half periods keep every pin change away from the system clock's sampling edges
   initial begin
      aux_clk = 1'b0;
      hclk    = 1'b0;
      bclk    = 1'b0;
      fs      = 1'b0;
   end
   always #100 aux_clk = ~aux_clk;
   always #100 hclk = ~hclk;
   always #150 bclk = ~bclk;
   // Sync period 2000 ns, rising edge marks the frame
   always begin
      #213 fs = 1'b1;
      #200 fs = 1'b0;
      #1587;
   end
endmodule
`default_nettype wire
